// *** hw/pcer_defines.svh ***
// constants for the pin and channel enable register pair
// assumes inclusion by bare name from the register design file; the package does not include it
`ifndef PCER_DEFINES_SVH
`define PCER_DEFINES_SVH

`define PCER_ADDR_GPIO      8'h11
`define PCER_ADDR_MEAS      8'h12
`define PCER_RESET_VALUE    16'h0000

// general pin control field layout
`define PCER_DIR_LSB        12
`define PCER_PST_LSB        8
`define PCER_TMR_BIT        7
`define PCER_LVL_LSB        0
`define PCER_GPIO_WMASK     16'hf08f
`define PCER_PIN3           3

// measurement channel enable field layout
`define PCER_BLKCONN_BIT    15
`define PCER_BLKMEAS_BIT    14
`define PCER_AUX2_BIT       13
`define PCER_AUX1_BIT       12
`define PCER_MEAS_WMASK     16'hffff
`define PCER_CELL_FIRST     4'h1
`define PCER_CELL_LAST      4'hc
`define PCER_CELL_MSB       11
`define PCER_ZERO_RESULT    16'h0000

`endif

// *** hw/pcer_pkg.sv ***
// types shared by the pin and channel enable register pair
// assumes the link decoder presents one register request per cycle
package pcer_pkg;

    // one register access from the serial link decoder
    typedef struct packed {
        logic [7:0]  addr;   // register address byte
        logic        wr;     // one-cycle write strobe
        logic        rd;     // pulse at end of address parity bit
        logic [15:0] wdata;  // write data word
    } pcer_req_t;

    // one conversion result from the acquisition sequencer
    typedef struct packed {
        logic        valid;  // one-cycle strobe
        logic [3:0]  index;  // cell number 1..12, others non-cell
        logic [15:0] data;   // raw result
    } pcer_conv_t;

endpackage : pcer_pkg

// *** hw/pcer_regs.sv ***
// general pin control and measurement channel enable registers
// assumes requests from the link decoder are synchronous to ref_clk
`timescale 1ns/1ns
`include "pcer_defines.svh"

module pcer_regs (
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    input  wire pcer_pkg::pcer_req_t req,
    output logic [15:0]             rdata,
    output logic                    rdata_valid,
    input  wire logic [3:0]         gpio_in,
    output logic [3:0]              gpio_out,
    output logic [3:0]              gpio_oe,
    input  wire logic               emergency_discharge_mode,
    input  wire logic               timer_counting,
    output logic                    block_divider_connect,
    output logic                    block_voltage_measure_enable,
    output logic                    aux2_measure_enable,
    output logic                    aux1_measure_enable,
    output logic [11:0]             cell_measure_enable,
    input  wire pcer_pkg::pcer_conv_t conv_in,
    output pcer_pkg::pcer_conv_t    conv_out
);

    ////////////////////////////////////////////////////////////////////
    // register state
    logic [15:0] gpio_reg, gpio_next;  // pin-state bits kept at zero
    logic [15:0] meas_reg, meas_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        rvalid_reg, rvalid_next;

    // write path and read capture
    always_comb begin
        gpio_next   = gpio_reg;
        meas_next   = meas_reg;
        rdata_next  = rdata_reg;
        rvalid_next = 1'b0;
        if (req.wr && req.addr == `PCER_ADDR_GPIO) begin
            gpio_next = req.wdata & `PCER_GPIO_WMASK;
        end
        if (req.wr && req.addr == `PCER_ADDR_MEAS) begin
            meas_next = req.wdata & `PCER_MEAS_WMASK;
        end
        if (req.rd) begin
            rvalid_next = 1'b1;
            case (req.addr)
                `PCER_ADDR_GPIO: begin
                    // levels caught on the parity-end strobe itself
                    rdata_next = gpio_reg;
                    rdata_next[`PCER_PST_LSB +: 4] = gpio_in;
                end
                `PCER_ADDR_MEAS: begin
                    rdata_next = meas_reg;
                end
                default: begin
                    rdata_next = `PCER_RESET_VALUE; // unmapped reads zero
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gpio_reg   <= `PCER_RESET_VALUE;
            meas_reg   <= `PCER_RESET_VALUE;
            rdata_reg  <= `PCER_RESET_VALUE;
            rvalid_reg <= 1'b0;
        end else begin
            gpio_reg   <= gpio_next;
            meas_reg   <= meas_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign rdata       = rdata_reg;
    assign rdata_valid = rvalid_reg;

    ////////////////////////////////////////////////////////////////////
    // pin drivers, registered so pins never glitch on decode
    logic [3:0] pout_reg, pout_next;
    logic [3:0] poe_reg, poe_next;
    logic       tmr_mode;

    always_comb begin
        // emergency discharge forces timer mode regardless of the bit
        tmr_mode  = gpio_reg[`PCER_TMR_BIT] | emergency_discharge_mode;
        poe_next  = gpio_reg[`PCER_DIR_LSB +: 4];
        pout_next = gpio_reg[`PCER_LVL_LSB +: 4] & poe_next;
        if (tmr_mode) begin
            poe_next[`PCER_PIN3]  = 1'b1;
            pout_next[`PCER_PIN3] = timer_counting;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pout_reg <= 4'h0;
            poe_reg  <= 4'h0;
        end else begin
            pout_reg <= pout_next;
            poe_reg  <= poe_next;
        end
    end

    assign gpio_out = pout_reg;
    assign gpio_oe  = poe_reg;

    ////////////////////////////////////////////////////////////////////
    // channel selection straight from the enable register
    assign block_divider_connect        = meas_reg[`PCER_BLKCONN_BIT];
    assign block_voltage_measure_enable = meas_reg[`PCER_BLKMEAS_BIT];
    assign aux2_measure_enable          = meas_reg[`PCER_AUX2_BIT];
    assign aux1_measure_enable          = meas_reg[`PCER_AUX1_BIT];
    assign cell_measure_enable          = meas_reg[`PCER_CELL_MSB:0];
    // the divider is not auto-connected: host must set it first

    ////////////////////////////////////////////////////////////////////
    // result masking; non-cell indices pass untouched
    pcer_pkg::pcer_conv_t conv_reg, conv_next;
    logic       is_cell;
    logic [3:0] cell_off;

    always_comb begin
        conv_next = conv_in;
        is_cell   = (conv_in.index >= `PCER_CELL_FIRST) &&
                    (conv_in.index <= `PCER_CELL_LAST);
        cell_off  = conv_in.index - `PCER_CELL_FIRST;
        if (is_cell && !meas_reg[cell_off]) begin
            conv_next.data = `PCER_ZERO_RESULT;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            conv_reg <= '0;
        end else begin
            conv_reg <= conv_next;
        end
    end

    assign conv_out = conv_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    chk_dir_enables_out: assert property (
        !$past(tmr_mode) |->
        gpio_oe == $past(gpio_reg[`PCER_DIR_LSB +: 4]))
        else $error("pin enable does not follow direction bits");
    chk_drive_level: assert property (
        !$past(tmr_mode) |->
        gpio_out == ($past(gpio_reg[`PCER_DIR_LSB +: 4]) &
                     $past(gpio_reg[`PCER_LVL_LSB +: 4])))
        else $error("pin level does not follow drive bits");
    chk_pst_readonly: assert property (
        gpio_reg[`PCER_PST_LSB +: 4] == '0)
        else $error("pin-state bits stored in register");
    chk_pst_sample: assert property (
        req.rd && req.addr == `PCER_ADDR_GPIO |=>
        rdata_valid && rdata[`PCER_PST_LSB +: 4] == $past(gpio_in))
        else $error("pin state not sampled on read strobe");
    chk_tmr_high: assert property (
        tmr_mode && timer_counting |=>
        gpio_oe[`PCER_PIN3] && gpio_out[`PCER_PIN3])
        else $error("pin 3 not high while timer counts");
    chk_tmr_low: assert property (
        tmr_mode && !timer_counting |=>
        gpio_oe[`PCER_PIN3] && !gpio_out[`PCER_PIN3])
        else $error("pin 3 not low after timer expiry");
    chk_emgcy_force: assert property (
        emergency_discharge_mode |=> gpio_oe[`PCER_PIN3])
        else $error("emergency discharge did not force timer mode");
    chk_meas_write: assert property (
        req.wr && req.addr == `PCER_ADDR_MEAS |=>
        block_divider_connect == $past(req.wdata[`PCER_BLKCONN_BIT]) &&
        cell_measure_enable == $past(req.wdata[`PCER_CELL_MSB:0]))
        else $error("enable register write lost");
    chk_meas_inputs: assert property (
        req.wr && req.addr == `PCER_ADDR_MEAS |=>
        block_voltage_measure_enable ==
            $past(req.wdata[`PCER_BLKMEAS_BIT]) &&
        aux2_measure_enable == $past(req.wdata[`PCER_AUX2_BIT]) &&
        aux1_measure_enable == $past(req.wdata[`PCER_AUX1_BIT]))
        else $error("input enable bits do not follow write");
    chk_cell_zero: assert property (
        conv_in.valid && conv_in.index == `PCER_CELL_FIRST &&
        !meas_reg[0] |=>
        conv_out.valid && conv_out.data == `PCER_ZERO_RESULT)
        else $error("disabled cell result not zero");
    chk_last_cell_zero: assert property (
        conv_in.valid && conv_in.index == `PCER_CELL_LAST &&
        !meas_reg[`PCER_CELL_MSB] |=>
        conv_out.valid && conv_out.data == `PCER_ZERO_RESULT)
        else $error("disabled last cell result not zero");
    chk_cell_passes: assert property (
        conv_in.valid && conv_in.index == `PCER_CELL_FIRST &&
        meas_reg[0] |=>
        conv_out.valid && conv_out.data == $past(conv_in.data))
        else $error("enabled cell result altered");
    chk_unused_zero: assert property (
        (gpio_reg & ~`PCER_GPIO_WMASK) == `PCER_RESET_VALUE)
        else $error("unused pin control bits set");
    chk_unmapped_read: assert property (
        req.rd && req.addr != `PCER_ADDR_GPIO &&
        req.addr != `PCER_ADDR_MEAS |=>
        rdata_valid && rdata == `PCER_RESET_VALUE)
        else $error("unmapped read not zero");
    chk_stray_write: assert property (
        req.wr && req.addr != `PCER_ADDR_GPIO &&
        req.addr != `PCER_ADDR_MEAS |=>
        gpio_reg == $past(gpio_reg) && meas_reg == $past(meas_reg))
        else $error("write to unmapped address changed a register");

endmodule : pcer_regs

// *** test/pcer_host.sv ***
// host side model: turns bench calls into register requests
// assumes the link decoder struct from pcer_pkg, one word per call
`timescale 1ns/1ns
module pcer_host (
    input  wire logic           ref_clk,
    output pcer_pkg::pcer_req_t req
);
    initial req = '0;
    // one-cycle strobe off the falling edge; released fields are
    // inverted so a stale address or word never looks valid
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [15:0] d);
        @(negedge ref_clk);
        req <= '{addr: a, wr: w, rd: !w, wdata: d};
        @(negedge ref_clk);
        req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask : access
endmodule : pcer_host

// *** test/pin_and_channel_enable_regs_bench.sv ***
// self-checking bench for the pin and channel enable registers
// assumes pcer_host as the link side and 125 MHz ref_clk
`timescale 1ns/1ns
module pin_and_channel_enable_regs_bench;
    logic                 ref_clk, nrst, em, tc, rv, bdc, bve, a2, a1;
    logic [3:0]           gin, gout, goe, eoe, eout;
    logic [15:0]          rdata, w, m;
    logic [11:0]          cme;
    pcer_pkg::pcer_req_t  req;
    pcer_pkg::pcer_conv_t cin, cout;
    logic [19:0]          rq[$], cq[$], er, ec;
    int                   n_fail = 0, num_checks = 0, seed = 57625, i, j;

    pcer_host pcer_host_inst (.ref_clk(ref_clk), .req(req));
    pcer_regs pcer_regs_inst (.ref_clk(ref_clk), .nrst(nrst), .req(req),
        .rdata(rdata), .rdata_valid(rv), .gpio_in(gin), .gpio_out(gout),
        .gpio_oe(goe), .emergency_discharge_mode(em),
        .timer_counting(tc), .block_divider_connect(bdc),
        .block_voltage_measure_enable(bve), .aux2_measure_enable(a2),
        .aux1_measure_enable(a1), .cell_measure_enable(cme),
        .conv_in(cin), .conv_out(cout));

    ////////////////////////////////////////////////////////////////////
    // compare, count and report at once
    task automatic cmp(input logic [19:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask : cmp

    // one compare task per kind of result, all counted by cmp
    task automatic cmp_read(input logic [19:0] got, exp);
        cmp(got, exp, "read");
    endtask : cmp_read
    task automatic cmp_conv(input logic [19:0] got, exp);
        cmp(got, exp, "conv");
    endtask : cmp_conv
    task automatic cmp_pins(input logic [7:0] got, exp);
        cmp({12'h000, got}, {12'h000, exp}, "pins");
    endtask : cmp_pins
    task automatic cmp_en(input logic [15:0] got, exp);
        cmp({4'h0, got}, {4'h0, exp}, "en");
    endtask : cmp_en

    // note the expected word before the read goes out
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        rq.push_back({4'h0, e});
        pcer_host_inst.access(1'b0, a, 16'h0000);
    endtask : rd

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // watcher: results are strobes, so sample mid-cycle
    always @(negedge ref_clk) begin
        if (rv === 1'b1) begin
            er = rq.size() ? rq.pop_front() : 20'hfffff;
            cmp_read({4'h0, rdata}, er);
        end
        if (cout.valid === 1'b1) begin
            ec = cq.size() ? cq.pop_front() : 20'hfffff;
            cmp_conv({cout.index, cout.data}, ec);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // main sequence
    initial begin
        nrst = 1'b0; em = 1'b0; tc = 1'b0; gin = 4'h0; cin = '0;
        repeat (12) @(negedge ref_clk);
        nrst = 1'b1;
        rd(8'h11, 16'h0000);
        rd(8'h12, 16'h0000);
        // unmapped space swallows writes and reads zero
        pcer_host_inst.access(1'b1, 8'h13, 16'hffff);
        rd(8'h13, 16'h0000);
        // random pin setups, timer override and emergency forcing
        for (i = 0; i < 16; i++) begin
            w = 16'($random(seed));
            {em, tc, gin} = 6'($random(seed));
            pcer_host_inst.access(1'b1, 8'h11, w);
            rd(8'h11, (w & 16'hf08f) | {4'h0, gin, 8'h00});
            repeat (2) @(negedge ref_clk);
            eoe = w[15:12];
            eout = w[15:12] & w[3:0];
            if (w[7] | em) begin
                eoe[3] = 1'b1;
                eout[3] = tc;
            end
            cmp_pins({goe, gout}, {eoe, eout});
        end
        // mid-run reset puts both registers and the pins back at rest
        em = 1'b0;
        @(negedge ref_clk);
        nrst = 1'b0;
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        cmp_pins({goe, gout}, 8'h00);
        rd(8'h11, {4'h0, gin, 8'h00});
        rd(8'h12, 16'h0000);
        // channel enables, then one result per index back to back
        for (i = 0; i < 8; i++) begin
            m = 16'($random(seed));
            m[15] = m[15] | m[14];
            pcer_host_inst.access(1'b1, 8'h12, m);
            rd(8'h12, m);
            cmp_en({bdc, bve, a2, a1, cme}, m);
            for (j = 0; j < 16; j++) begin
                cin = '{valid: 1'b1, index: 4'(j),
                        data: 16'($random(seed))};
                cq.push_back({cin.index, (j >= 1 && j <= 12 && !m[j-1])
                              ? 16'h0000 : cin.data});
                @(negedge ref_clk);
            end
            cin = '0;
        end
        // drain, bounded
        for (i = 0; i < 50 && (rq.size() || cq.size()); i++)
            @(negedge ref_clk);
        if (rq.size() || cq.size()) begin
            n_fail++;
            $display("MISMATCH t=%0t results still owed at drain", $time);
        end
        tally_and_finish();
    end
endmodule : pin_and_channel_enable_regs_bench
